// ### adc_channel_model.sv
// Behavioural model of the multiplexed ADC that answers the sequencer's channel select
`timescale 1ns/100ps
`default_nettype none
module adc_channel_model (
  input wire logic i_clk,
  input wire logic [1:0] i_channel,
  input wire logic signed [15:0] i_temp_val,
  input wire logic signed [15:0] i_shunt_val,
  input wire logic signed [15:0] i_bus_val,
  output logic signed [15:0] o_adc_data
);
  import power_seq_pkg::*;
  logic [15:0] idle_pattern_reg;
  // Idle data steps by 16'h3A5B every cycle, so a stray sample is unlikely to match a channel value
  always @(posedge i_clk) begin
    idle_pattern_reg <= idle_pattern_reg + 16'h3A5B;
  end
  initial idle_pattern_reg = 16'h5A5A;
  always_comb begin
    case (i_channel)
      CH_TEMP: o_adc_data = i_temp_val;
      CH_SHUNT: o_adc_data = i_shunt_val;
      CH_BUS: o_adc_data = i_bus_val;
      default: o_adc_data = idle_pattern_reg;
    endcase
  end
endmodule
`default_nettype wire

// ### interval_timer.sv
// Microsecond interval timer that times conversions and the start delay
`timescale 1ns/100ps
`default_nettype none
module interval_timer #(
  parameter int US_CYCLES = power_seq_pkg::US_CYCLES_DFLT
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire logic [19:0] i_target_us,
  output logic o_done
);
  import power_seq_pkg::*;

  localparam logic [15:0] PRE_LAST = 16'(US_CYCLES - 1);

  timer_state_t state_reg;
  timer_state_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    if (i_start) begin
      // A new start always restarts, so an aborted interval never fires late
      state_next.active = 1'b1;
      state_next.pre = '0;
      state_next.us = '0;
      state_next.target = i_target_us;
    end else if (state_reg.active) begin
      if (state_reg.us == state_reg.target) begin
        state_next.active = 1'b0;
        state_next.done = 1'b1;
      end else if (state_reg.pre == PRE_LAST) begin
        state_next.pre = '0;
        state_next.us = state_reg.us + 20'h00001;
      end else begin
        state_next.pre = state_reg.pre + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_done = state_reg.done;

endmodule
`default_nettype wire

// ### power_seq.sv
// Conversion sequencer and background calculation engine of the power monitor
`timescale 1ns/100ps
`default_nettype none
// Function
// [R01] Power and energy use the previous current and the newest bus voltage sample.
// [R02] With one average, each result goes to the outputs when its conversion ends.
// [R03] With averaging, samples accumulate until the count, then averages and power load.
// [R04] Energy and charge accumulate every conversion cycle, never averaged.
// [R05] Power, charge and energy arithmetic runs alongside conversions, adding no time.
// [R06] A temperature conversion precedes every shunt conversion and corrects current.
// [R07] Modes may restrict conversions to current only or bus voltage only.
// [R08] Shunt, bus and temperature periods are each programmable from 50 us to 4.12 ms.
// [R09] Current is ready after temperature plus shunt conversion, up to 8.24 ms.
// [R10] Enabled channels convert in turn; the sequence repeats per averaged sample.
// [R11] Outputs hold until a complete new set replaces them; reads never disturb.
// [R12] Continuous mode repeats conversion, averaging and update without end.
// [R13] Triggered mode runs one sequence then shuts down; host rewrites mode for more.
// [R14] A mode write aborts the running conversion and restarts with the new setting.
// [R15] Ready flag sets only when all conversions and averaging of the set finish.
// [R16] Ready clears on a non-shutdown setup write and on a diagnostic register read.
// [R17] Energy and charge are invalid in triggered mode; host uses continuous mode.
// [R18] Start of conversions is delayed 0 to 510 ms in 2 ms steps, 0 ms at reset.
// [R19] Each conversion settles within its own period; no filter state carries over.
// [R20] One average count, 1 to 1024, applies to every active channel alike.
// [R21] Settings stay writable in shutdown; a trigger from shutdown runs then returns.
// [R22] A restart discards partly filled accumulators.
module power_seq #(
  parameter int US_CYCLES = power_seq_pkg::US_CYCLES_DFLT
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_setup_wr,
  input wire power_seq_pkg::setup_t i_setup,
  input wire logic [7:0] i_start_delay_field,
  input wire logic i_diag_rd,
  input wire logic signed [15:0] i_adc_data,
  output logic [1:0] o_adc_channel,
  output power_seq_pkg::results_t o_results,
  output logic o_conversion_ready_flag,
  output logic o_shutdown,
  output logic o_accum_valid
);
  import power_seq_pkg::*;

  function automatic logic signed [15:0] tcomp(input logic signed [15:0] shunt,
                                               input logic signed [15:0] temp);
    logic signed [16:0] dt;
    logic signed [47:0] prod;
    dt = 17'(temp) - 17'(TCOMP_REF);
    prod = 48'(shunt) * 48'(dt) * 48'(TCOMP_COEF);
    tcomp = shunt + 16'(prod >>> TCOMP_SHIFT);
  endfunction

  seq_state_t state_reg;
  seq_state_t state_next;
  logic tmr_start;
  logic [19:0] tmr_target;
  logic tmr_done;
  logic sample_end;
  logic set_ready;
  logic avg1;
  logic [3:0] shift;
  logic [10:0] last_sample;
  logic signed [15:0] cur_now;
  logic signed [31:0] pwr_now;
  logic signed [ACC_W-1:0] avg_cur;
  logic signed [ACC_W-1:0] avg_bus;
  logic signed [ACC_W-1:0] avg_temp;
  seq_st_t first_st;

  interval_timer #(
    .US_CYCLES(US_CYCLES)
  ) u_timer (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(tmr_start),
    .i_target_us(tmr_target),
    .o_done(tmr_done)
  );

  always_comb begin
    state_next = state_reg;
    tmr_start = 1'b0;
    tmr_target = '0;
    sample_end = 1'b0;
    set_ready = 1'b0;
    shift = avg_shift(state_reg.cfg.avg_sel);
    avg1 = (shift == 4'h0);
    last_sample = 11'((32'h1 << shift) - 32'h1);
    first_st = state_reg.cfg.mode[MODE_CUR_BIT] ? ST_TEMP : ST_BUS; // [R07]
    cur_now = tcomp(i_adc_data, state_reg.temp_raw);
    pwr_now = 32'(state_reg.last_current) * 32'(i_adc_data);
    avg_cur = state_reg.acc_cur >>> shift;
    avg_bus = state_reg.acc_bus >>> shift;
    avg_temp = state_reg.acc_temp >>> shift;
    if (i_setup_wr) begin
      // Abort whatever runs and drop partial sums so the next set is clean
      state_next.cfg = i_setup; // [R14] [R21]
      state_next.acc_cur = '0; // [R22]
      state_next.acc_bus = '0;
      state_next.acc_temp = '0;
      state_next.samples = '0;
      state_next.accum_valid = i_setup.mode[MODE_CONT_BIT]; // [R17]
      if (i_setup.mode[MODE_CUR_BIT] | i_setup.mode[MODE_BUS_BIT]) begin
        state_next.st = ST_DELAY; // [R14]
        state_next.ready = 1'b0; // [R16]
        tmr_start = 1'b1;
      end else begin
        state_next.st = ST_SHUTDOWN;
      end
    end else begin
      case (state_reg.st)
        ST_SHUTDOWN: begin
          state_next.st = ST_SHUTDOWN;
        end
        ST_DELAY: begin
          if (tmr_done) begin
            state_next.st = first_st; // [R18]
            tmr_start = 1'b1;
          end
        end
        ST_TEMP: begin
          if (tmr_done) begin
            // Each sample is taken fresh at its period end; the filter restarts per slot
            state_next.temp_raw = i_adc_data; // [R19]
            if (avg1) begin
              state_next.res.temp = i_adc_data; // [R02]
            end else begin
              state_next.acc_temp = state_reg.acc_temp + ACC_W'(i_adc_data); // [R03]
            end
            state_next.st = ST_SHUNT; // [R06] [R09]
            tmr_start = 1'b1;
          end
        end
        ST_SHUNT: begin
          if (tmr_done) begin
            state_next.last_current = cur_now; // [R06]
            state_next.res.charge = state_reg.res.charge + 40'(cur_now); // [R04] [R05]
            if (avg1) begin
              state_next.res.current = cur_now; // [R02]
            end else begin
              state_next.acc_cur = state_reg.acc_cur + ACC_W'(cur_now); // [R03]
            end
            if (state_reg.cfg.mode[MODE_BUS_BIT]) begin
              state_next.st = ST_BUS; // [R10]
              tmr_start = 1'b1;
            end else begin
              sample_end = 1'b1;
            end
          end
        end
        ST_BUS: begin
          if (tmr_done) begin
            // Energy takes its product in the same cycle, so no time is added
            state_next.res.energy = state_reg.res.energy + 40'(pwr_now); // [R01] [R04] [R05]
            if (avg1) begin
              state_next.res.vbus = i_adc_data; // [R02]
              state_next.res.power = pwr_now; // [R01]
            end else begin
              state_next.acc_bus = state_reg.acc_bus + ACC_W'(i_adc_data); // [R03]
            end
            sample_end = 1'b1;
          end
        end
        ST_LOAD: begin
          if (!avg1) begin
            if (state_reg.cfg.mode[MODE_CUR_BIT]) begin
              state_next.res.current = avg_cur[15:0]; // [R03] [R11]
              state_next.res.temp = avg_temp[15:0];
            end
            if (state_reg.cfg.mode[MODE_BUS_BIT]) begin
              state_next.res.vbus = avg_bus[15:0]; // [R03]
            end
            if (state_reg.cfg.mode[MODE_CUR_BIT] & state_reg.cfg.mode[MODE_BUS_BIT]) begin
              // Part-selects are unsigned, so the sign is restored before widening
              state_next.res.power = 32'(signed'(avg_cur[15:0]))
                * 32'(signed'(avg_bus[15:0])); // [R03]
            end
          end
          state_next.acc_cur = '0;
          state_next.acc_bus = '0;
          state_next.acc_temp = '0;
          state_next.samples = '0;
          set_ready = 1'b1; // [R15]
          if (state_reg.cfg.mode[MODE_CONT_BIT]) begin
            state_next.st = first_st; // [R12]
            tmr_start = 1'b1;
          end else begin
            state_next.st = ST_SHUTDOWN; // [R13] [R21]
          end
        end
        default: begin
          state_next.st = ST_SHUTDOWN;
        end
      endcase
      if (sample_end) begin
        if (state_reg.samples == last_sample) begin
          state_next.st = ST_LOAD; // [R20]
        end else begin
          state_next.samples = state_reg.samples + 11'h001; // [R10]
          state_next.st = first_st;
          tmr_start = 1'b1;
        end
      end
    end
    // A completion in the same cycle as a diagnostic read keeps the flag set
    if (set_ready) begin
      state_next.ready = 1'b1; // [R15]
    end else if (i_diag_rd) begin
      state_next.ready = 1'b0; // [R16]
    end
    case (state_next.st)
      ST_DELAY: tmr_target = 20'(i_start_delay_field) * DELAY_STEP_US; // [R18]
      ST_TEMP: tmr_target = conv_period_us(state_next.cfg.temp_ct); // [R08]
      ST_SHUNT: tmr_target = conv_period_us(state_next.cfg.shunt_ct); // [R08]
      ST_BUS: tmr_target = conv_period_us(state_next.cfg.bus_ct); // [R08]
      default: tmr_target = '0;
    endcase
    case (state_next.st)
      ST_TEMP: state_next.chan = CH_TEMP;
      ST_SHUNT: state_next.chan = CH_SHUNT;
      ST_BUS: state_next.chan = CH_BUS;
      default: state_next.chan = CH_IDLE;
    endcase
    state_next.shutdown = (state_next.st == ST_SHUTDOWN);
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= '0;
      state_reg.st <= ST_SHUTDOWN;
      state_reg.cfg <= SETUP_RESET;
      state_reg.shutdown <= 1'b1;
      state_reg.chan <= CH_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_adc_channel = state_reg.chan;
  assign o_results = state_reg.res;
  assign o_conversion_ready_flag = state_reg.ready;
  assign o_shutdown = state_reg.shutdown;
  assign o_accum_valid = state_reg.accum_valid;

  a_ready_on_load: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R15]
    (state_reg.st == ST_LOAD && !i_setup_wr) |=> o_conversion_ready_flag)
    else $error("ready flag not set after result load");

  a_ready_only_load: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R15]
    $rose(o_conversion_ready_flag) |-> $past(state_reg.st == ST_LOAD))
    else $error("ready flag set without a completed set");

  a_ready_clr_setup: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R16]
    (i_setup_wr && (i_setup.mode[MODE_CUR_BIT] || i_setup.mode[MODE_BUS_BIT]))
    |=> !o_conversion_ready_flag)
    else $error("ready flag not cleared by setup write");

  a_ready_clr_diag: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R16]
    (i_diag_rd && !i_setup_wr && state_reg.st != ST_LOAD) |=> !o_conversion_ready_flag)
    else $error("ready flag not cleared by diagnostic read");

  a_temp_first: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R06]
    (state_reg.st == ST_SHUNT && $past(state_reg.st) != ST_SHUNT)
    |-> $past(state_reg.st) == ST_TEMP)
    else $error("shunt conversion not preceded by temperature");

  a_trig_shutdown: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R13]
    (state_reg.st == ST_LOAD && !state_reg.cfg.mode[MODE_CONT_BIT] && !i_setup_wr)
    |=> o_shutdown && state_reg.st == ST_SHUTDOWN)
    else $error("triggered run did not return to shutdown");

  a_cont_repeat: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R12]
    (state_reg.st == ST_LOAD && state_reg.cfg.mode[MODE_CONT_BIT] && !i_setup_wr)
    |=> (state_reg.st == ST_TEMP || state_reg.st == ST_BUS) && !o_shutdown)
    else $error("continuous run did not restart");

  a_mode_restart: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R14]
    (i_setup_wr && (i_setup.mode[MODE_CUR_BIT] || i_setup.mode[MODE_BUS_BIT]))
    |=> state_reg.st == ST_DELAY && state_reg.samples == 11'h000)
    else $error("mode write did not restart the sequence");

  a_bus_skipped: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R07]
    (state_reg.cfg.mode[MODE_BUS_BIT] == 1'b0) |-> state_reg.st != ST_BUS)
    else $error("bus converted in current-only mode");

  a_current_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R11]
    $changed(o_results.current)
    |-> $past(state_reg.st == ST_LOAD || (state_reg.st == ST_SHUNT && tmr_done)))
    else $error("current output changed outside a result update");

  a_avg1_direct: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R02]
    (state_reg.st == ST_BUS && tmr_done && !i_setup_wr && avg1)
    |=> o_results.vbus == $past(i_adc_data))
    else $error("single-average bus result not loaded directly");

endmodule
`default_nettype wire

// ### power_seq_pkg.sv
// Shared constants, field layouts and state types of the conversion sequencer
package power_seq_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_US = 1000;
  localparam int US_CYCLES_DFLT = (NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int US_PER_MS = 1000;

  // Start delay: field times 2 ms, 0 ms after reset
  localparam int DELAY_STEP_MS = 2;
  localparam logic [19:0] DELAY_STEP_US = 20'(DELAY_STEP_MS * US_PER_MS);
  localparam logic [7:0] START_DELAY_RESET = 8'h00;

  // Conversion periods per code, in microseconds
  localparam logic [19:0] CT_US_0 = 20'd50;
  localparam logic [19:0] CT_US_1 = 20'd84;
  localparam logic [19:0] CT_US_2 = 20'd150;
  localparam logic [19:0] CT_US_3 = 20'd280;
  localparam logic [19:0] CT_US_4 = 20'd540;
  localparam logic [19:0] CT_US_5 = 20'd1052;
  localparam logic [19:0] CT_US_6 = 20'd2074;
  localparam logic [19:0] CT_US_7 = 20'd4120;

  // Mode field bit positions; both enable bits low means shutdown
  localparam int MODE_CUR_BIT = 0;
  localparam int MODE_BUS_BIT = 1;
  localparam int MODE_CONT_BIT = 2;
  localparam logic [2:0] MODE_RESET = 3'h7;

  // ADC channel select codes
  localparam logic [1:0] CH_TEMP = 2'h0;
  localparam logic [1:0] CH_SHUNT = 2'h1;
  localparam logic [1:0] CH_BUS = 2'h2;
  localparam logic [1:0] CH_IDLE = 2'h3;

  // Temperature correction of the current: i + i*(t-ref)*coef >> shift
  localparam logic signed [15:0] TCOMP_REF = 16'sh0C80;
  localparam logic signed [15:0] TCOMP_COEF = 16'sh0001;
  localparam int TCOMP_SHIFT = 20;

  localparam int ACC_W = 26;
  localparam logic [2:0] AVG_RESET = 3'h0;
  localparam logic [2:0] CT_RESET = 3'h5;

  typedef struct packed {
    logic [2:0] mode;
    logic [2:0] bus_ct;
    logic [2:0] shunt_ct;
    logic [2:0] temp_ct;
    logic [2:0] avg_sel;
  } setup_t;

  localparam setup_t SETUP_RESET = '{MODE_RESET, CT_RESET, CT_RESET, CT_RESET, AVG_RESET};

  typedef struct packed {
    logic signed [15:0] current;
    logic signed [15:0] vbus;
    logic signed [15:0] temp;
    logic signed [31:0] power;
    logic signed [39:0] energy;
    logic signed [39:0] charge;
  } results_t;

  typedef enum logic [2:0] {
    ST_SHUTDOWN,
    ST_DELAY,
    ST_TEMP,
    ST_SHUNT,
    ST_BUS,
    ST_LOAD
  } seq_st_t;

  typedef struct packed {
    seq_st_t st;
    setup_t cfg;
    logic signed [15:0] temp_raw;
    logic signed [15:0] last_current;
    logic signed [ACC_W-1:0] acc_cur;
    logic signed [ACC_W-1:0] acc_bus;
    logic signed [ACC_W-1:0] acc_temp;
    logic [10:0] samples;
    results_t res;
    logic ready;
    logic shutdown;
    logic accum_valid;
    logic [1:0] chan;
  } seq_state_t;

  typedef struct packed {
    logic active;
    logic done;
    logic [15:0] pre;
    logic [19:0] us;
    logic [19:0] target;
  } timer_state_t;

  // Period of a channel code in microseconds
  function automatic logic [19:0] conv_period_us(input logic [2:0] code);
    case (code)
      3'h0: conv_period_us = CT_US_0;
      3'h1: conv_period_us = CT_US_1;
      3'h2: conv_period_us = CT_US_2;
      3'h3: conv_period_us = CT_US_3;
      3'h4: conv_period_us = CT_US_4;
      3'h5: conv_period_us = CT_US_5;
      3'h6: conv_period_us = CT_US_6;
      default: conv_period_us = CT_US_7;
    endcase
  endfunction

  // Averaging count is a power of two: 1,4,16,64,128,256,512,1024
  function automatic logic [3:0] avg_shift(input logic [2:0] code);
    case (code)
      3'h0: avg_shift = 4'h0;
      3'h1: avg_shift = 4'h2;
      3'h2: avg_shift = 4'h4;
      3'h3: avg_shift = 4'h6;
      3'h4: avg_shift = 4'h7;
      3'h5: avg_shift = 4'h8;
      3'h6: avg_shift = 4'h9;
      default: avg_shift = 4'hA;
    endcase
  endfunction

endpackage

// ### tb_power_seq.sv
// Self-checking testbench of the conversion sequencer with an ADC model
`timescale 1ns/100ps
`default_nettype none
module tb_power_seq;
  import power_seq_pkg::*;
  localparam int US = 1;
  localparam logic signed [15:0] TEMP_V = 16'sh0D80;
  logic i_clk = 1'b0;
  logic i_sys_rst, i_setup_wr, i_diag_rd;
  setup_t i_setup;
  logic [7:0] i_start_delay_field;
  logic signed [15:0] adc_data, temp_v, shunt_v, bus_v;
  logic [1:0] chan;
  results_t res;
  logic ready, shutdown, accum_valid;
  int fails = 0;
  int total_checks = 0;
  int slot_cnt[4] = '{0, 0, 0, 0};
  int slot_len[4] = '{0, 0, 0, 0};
  int base[4];
  int run = 0;
  logic [1:0] prev_ch = 2'h3;

  always #5 i_clk = ~i_clk;

  power_seq #(.US_CYCLES(US)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_setup_wr(i_setup_wr), .i_setup(i_setup), .i_start_delay_field(i_start_delay_field),
    .i_diag_rd(i_diag_rd), .i_adc_data(adc_data), .o_adc_channel(chan), .o_results(res),
    .o_conversion_ready_flag(ready), .o_shutdown(shutdown), .o_accum_valid(accum_valid));
  adc_channel_model adc (.i_clk(i_clk), .i_channel(chan), .i_temp_val(temp_v),
    .i_shunt_val(shunt_v), .i_bus_val(bus_v), .o_adc_data(adc_data));

  // Slot monitor: length and number of each channel's conversion slots, sampled off the launch edge
  always @(negedge i_clk) begin
    if (chan !== prev_ch) begin
      slot_len[prev_ch] <= run;
      slot_cnt[prev_ch] <= slot_cnt[prev_ch] + 1;
      run <= 1;
    end else begin
      run <= run + 1;
    end
    prev_ch <= chan;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check_val(input string name, input logic [39:0] exp, input logic [39:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic check_flag(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic setup_write(input logic [2:0] mode, input logic [2:0] avg, input logic [7:0] dly);
    @(negedge i_clk);
    i_setup <= '{mode, 3'h2, 3'h1, 3'h0, avg};
    i_start_delay_field <= dly;
    i_setup_wr <= 1'b1;
    @(negedge i_clk);
    i_setup_wr <= 1'b0;
  endtask

  task automatic diag_read();
    @(negedge i_clk);
    i_diag_rd <= 1'b1;
    @(negedge i_clk);
    i_diag_rd <= 1'b0;
  endtask

  // Code 4 waits for the ready flag, codes 0 to 3 for that channel
  task automatic wait_until(input logic [2:0] what, input int max);
    int n;
    for (n = 0; n < max; n++) begin
      @(negedge i_clk);
      if ((what == 3'h4) ? (ready === 1'b1) : (chan === what[1:0])) break;
    end
    total_checks++;
    if (n == max) begin
      fails++;
      $display("unexpected wait %0d expected reached seen timeout", what);
    end
  endtask

  function automatic logic signed [15:0] exp_cur(input logic signed [15:0] s,
                                                input logic signed [15:0] t);
    logic signed [47:0] p;
    p = s;
    p = p * (t - TCOMP_REF) * TCOMP_COEF;
    exp_cur = s + 16'(p >>> TCOMP_SHIFT);
  endfunction

  initial begin
    #600000;
    fails++;
    print_verdict();
  end

  initial begin
    logic signed [15:0] cur1, cur2;
    logic signed [31:0] pw1;
    logic [39:0] c1, e1;
    i_sys_rst = 1'b1;
    i_setup_wr = 1'b0;
    i_diag_rd = 1'b0;
    i_setup = SETUP_RESET;
    i_start_delay_field = 8'h00;
    temp_v = TEMP_V;
    shunt_v = 16'sh1000;
    bus_v = 16'sh0200;
    cur1 = exp_cur(16'sh1000, TEMP_V);
    pw1 = cur1 * 16'sh0200;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    i_sys_rst = 1'b0;
    check_flag("ready", 1'b0, ready);
    check_flag("shutdown", 1'b1, shutdown);
    check_flag("accum_valid", 1'b0, accum_valid);
    check_val("channel", 40'h3, 40'(chan));
    check_flag("results_zero", 1'b1, res === '0);
    // Triggered, current and bus, one average
    setup_write(3'b011, 3'h0, 8'h00);
    check_flag("shutdown", 1'b0, shutdown);
    check_val("channel", 40'h3, 40'(chan));
    wait_until(3'h1, 200);
    repeat (2) @(negedge i_clk);
    check_val("temp", 40'(TEMP_V), 40'(res.temp));
    check_flag("ready", 1'b0, ready);
    wait_until(3'h4, 600);
    check_flag("shutdown", 1'b1, shutdown);
    check_flag("accum_valid", 1'b0, accum_valid);
    check_val("current", 40'(cur1), 40'(res.current));
    check_val("vbus", 40'h0200, 40'(res.vbus));
    check_val("power", 40'(pw1), 40'(res.power));
    check_val("energy", 40'(signed'(pw1)), res.energy);
    check_val("charge", 40'(cur1), res.charge);
    check_val("shunt_len", 40'(34 * US), 40'(slot_len[1] - slot_len[0]));
    check_val("bus_len", 40'(100 * US), 40'(slot_len[2] - slot_len[0]));
    check_val("slots", 40'h111, 40'(slot_cnt[0] * 256 + slot_cnt[1] * 16 + slot_cnt[2]));
    check_flag("fast_load", 1'b1, run <= 4);
    // Continuous with a 2 ms start delay; totals are only trusted in this mode
    setup_write(3'b111, 3'h0, 8'h01);
    repeat (1995 * US) @(negedge i_clk);
    check_val("channel", 40'h3, 40'(chan));
    wait_until(3'h0, 40);
    wait_until(3'h4, 600);
    check_flag("shutdown", 1'b0, shutdown);
    check_flag("accum_valid", 1'b1, accum_valid);
    c1 = res.charge;
    e1 = res.energy;
    wait_until(3'h0, 5);
    diag_read();
    check_flag("ready", 1'b0, ready);
    wait_until(3'h4, 600);
    check_val("charge_step", 40'(cur1), res.charge - c1);
    check_val("energy_step", 40'(signed'(pw1)), res.energy - e1);
    // Abort into an averaged current-only triggered run, then abort that after one sample
    setup_write(3'b001, 3'h1, 8'h00);
    check_flag("ready", 1'b0, ready);
    check_val("channel", 40'h3, 40'(chan));
    wait_until(3'h1, 200);
    wait_until(3'h0, 200);
    shunt_v = 16'sh2000;
    cur2 = exp_cur(16'sh2000, TEMP_V);
    // A stale partial sum of the old shunt value would spoil the average below
    setup_write(3'b001, 3'h1, 8'h00);
    @(negedge i_clk);
    base = slot_cnt;
    c1 = res.charge;
    wait_until(3'h1, 200);
    wait_until(3'h0, 200);
    wait_until(3'h1, 200);
    check_val("current", 40'(cur1), 40'(res.current));
    wait_until(3'h4, 1500);
    check_val("current", 40'(cur2), 40'(res.current));
    check_val("vbus", 40'h0200, 40'(res.vbus));
    check_val("temp_slots", 40'd4, 40'(slot_cnt[0] - base[0]));
    check_val("shunt_slots", 40'd4, 40'(slot_cnt[1] - base[1]));
    check_val("bus_slots", 40'd0, 40'(slot_cnt[2] - base[2]));
    check_val("charge_sum", 40'(4 * cur2), res.charge - c1);
    check_flag("shutdown", 1'b1, shutdown);
    // Shutdown write keeps the flag, diagnostic read clears it
    setup_write(3'b000, 3'h0, 8'h00);
    check_flag("ready", 1'b1, ready);
    check_flag("shutdown", 1'b1, shutdown);
    diag_read();
    check_flag("ready", 1'b0, ready);
    // Bus-only triggered run uses the last current for power; a fresh mode write starts it
    bus_v = 16'sh0300;
    pw1 = cur2 * 16'sh0300;
    setup_write(3'b010, 3'h0, 8'h00);
    @(negedge i_clk);
    base = slot_cnt;
    wait_until(3'h4, 600);
    check_val("vbus", 40'h0300, 40'(res.vbus));
    check_val("power", 40'(pw1), 40'(res.power));
    check_val("current", 40'(cur2), 40'(res.current));
    check_val("cur_slots", 40'd0, 40'(slot_cnt[0] + slot_cnt[1] - base[0] - base[1]));
    print_verdict();
  end
endmodule
`default_nettype wire
